/* hw/ppms_map.vh */
// ppms_map.vh - constants of the peripheral pin multiplexer
// assumes inclusion by bare name from the design files under hw/
`ifndef PPMS_MAP_VH
`define PPMS_MAP_VH

// external_bus_select_reg layout
`define PPMS_SEL_RESET       16'h0000
`define PPMS_PP_LSB          12
`define PPMS_PP_MSB          14
`define PPMS_SP1_LSB         10
`define PPMS_SP1_MSB         11
`define PPMS_ADDR_LSB        0
`define PPMS_ADDR_MSB        5

// pulldown inhibit registers, reset leaves every pulldown on
`define PPMS_PD_RESET        16'h0000
`define PPMS_PDC_LSB         2
`define PPMS_PDC_MSB         15
`define PPMS_PDA_LSB         0
`define PPMS_PDA_MSB         5

// parallel-port route codes
`define PPMS_PP_LCD          3'h0
`define PPMS_PP_SPI_UART     3'h1
`define PPMS_PP_GPIO         3'h2
`define PPMS_PP_SPI_I2S3     3'h3
`define PPMS_PP_I2S2_UART    3'h4
`define PPMS_PP_SPI_UARTH    3'h5
`define PPMS_PP_SPI_I2S      3'h6

// serial-port-1 route codes
`define PPMS_SP1_CARD        2'h0
`define PPMS_SP1_I2S         2'h1
`define PPMS_SP1_GPIO        2'h2

// source index space, 7 bits
`define PPMS_SRC_W           7
`define PPMS_SRC_N           88
`define PPMS_SRC_GP          7'h00
`define PPMS_SRC_LCD         7'h20
`define PPMS_SRC_SPI         7'h35
`define PPMS_SRC_UART        7'h3c
`define PPMS_SRC_I2S2        7'h40
`define PPMS_SRC_I2S3        7'h44
`define PPMS_SRC_CARD        7'h48
`define PPMS_SRC_I2S1        7'h4e
`define PPMS_SRC_ADDR        7'h52

// spi sub-index within its group
`define PPMS_SPI_CLK         7'h00
`define PPMS_SPI_CS0         7'h01
`define PPMS_SPI_RX          7'h05
`define PPMS_SPI_TX          7'h06

// pad index space
`define PPMS_PAD_N           33
`define PPMS_PAD_SP1         21
`define PPMS_PAD_ADDR        27

`endif

/* hw/ppms_pin_slice.v */
// ppms_pin_slice.v - one shared pad: picks its source and registers it
// assumes the source vectors are synchronous to clock_i
`timescale 1ns/10ps
`default_nettype none
`include "ppms_map.vh"

module ppms_pin_slice (
	input  wire                     clock_i,
	input  wire                     rst_n_i,
	input  wire [`PPMS_SRC_W-1:0]   sel_i,
	input  wire [`PPMS_SRC_N-1:0]   src_out_i,
	input  wire [`PPMS_SRC_N-1:0]   src_oe_i,
	output reg                      pad_out_o,
	output reg                      pad_oe_o
);

	////////////////////////////////////////////////////////////////////////
	// registered pad drive from the selected source
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_out_o <= 1'b0;
			pad_oe_o  <= 1'b0;
		end else begin
			pad_out_o <= src_out_i[sel_i];
			pad_oe_o  <= src_oe_i[sel_i];
		end
	end

endmodule // ppms_pin_slice
`default_nettype wire

/* hw/ppms_pin_mux.v */
// ppms_pin_mux.v - peripheral pin multiplexer for three pin groups
// assumes all inputs synchronous to clock_i; pads resolved outside
`timescale 1ns/10ps
`default_nettype none
`include "ppms_map.vh"

module ppms_pin_mux (
	input  wire        clock_i,
	input  wire        rst_n_i,
	// register load strobes and shared write data
	input  wire        select_wr_i,
	input  wire        pd_c_wr_i,
	input  wire        pd_a_wr_i,
	input  wire [15:0] wr_data_i,
	output wire [15:0] external_bus_select_reg_o,
	output wire [15:0] pulldown_inhibit_reg_c_o,
	output wire [15:0] pulldown_inhibit_reg_a_o,
	// pulldown enables of controllable pins
	output reg  [15:2] pport_pulldown_en_o,
	output reg  [5:0]  sport1_pulldown_en_o,
	// pads: 0-15 lcd data, 16 en, 17 cs0, 18 cs1, 19 rw, 20 rs,
	// 21-26 serial port 1, 27-32 address 15-20
	input  wire [32:0] pad_in_i,
	output wire [32:0] pad_out_o,
	output wire [32:0] pad_oe_o,
	// general purpose io, indexed by line number
	input  wire [31:0] gp_out_i,
	input  wire [31:0] gp_oe_i,
	output wire [31:0] gp_in_o,
	// lcd bridge, indexed as the pads
	input  wire [20:0] lcd_out_i,
	input  wire [20:0] lcd_oe_i,
	output wire [20:0] lcd_in_o,
	// spi: clk, cs0, cs1, cs2, cs3, rx, tx
	input  wire [6:0]  spi_out_i,
	input  wire [6:0]  spi_oe_i,
	output wire [6:0]  spi_in_o,
	// uart: rts, cts, rxd, txd
	input  wire [3:0]  uart_out_i,
	input  wire [3:0]  uart_oe_i,
	output wire [3:0]  uart_in_o,
	// i2s port 2: clk, fs, rx, dx
	input  wire [3:0]  i2s2_out_i,
	input  wire [3:0]  i2s2_oe_i,
	output wire [3:0]  i2s2_in_o,
	// i2s port 3: clk, fs, rx, dx
	input  wire [3:0]  i2s3_out_i,
	input  wire [3:0]  i2s3_oe_i,
	output wire [3:0]  i2s3_in_o,
	// card port 1: clock, command, data 0-3
	input  wire [5:0]  card1_out_i,
	input  wire [5:0]  card1_oe_i,
	output wire [5:0]  card1_in_o,
	// i2s port 1: clk, fs, dx, rx
	input  wire [3:0]  i2s1_out_i,
	input  wire [3:0]  i2s1_oe_i,
	output wire [3:0]  i2s1_in_o,
	// external memory address lines 15-20, output only
	input  wire [5:0]  mem_addr_i
);

	////////////////////////////////////////////////////////////////////////
	// routing decode functions

	// source of parallel-port pad p under route code m
	function [`PPMS_SRC_W-1:0] pp_src;
		input [2:0] m;
		input [4:0] p;
		reg   [6:0] lcd;
		reg   [6:0] q;
		begin
			lcd = `PPMS_SRC_LCD + {2'h0, p};
			q   = {2'h0, p} - 7'h08;
			pp_src = lcd;
			if (m == `PPMS_PP_SPI_UART || m == `PPMS_PP_SPI_I2S) begin
				if (p >= 5'd16)
					pp_src = `PPMS_SRC_SPI + {2'h0, p} - 7'h10;
				else if (p == 5'd0)
					pp_src = `PPMS_SRC_SPI + `PPMS_SPI_RX;
				else if (p == 5'd1)
					pp_src = `PPMS_SRC_SPI + `PPMS_SPI_TX;
				else if (p <= 5'd7)
					pp_src = `PPMS_SRC_GP + {2'h0, p} + 7'h0a;
			end
			if (p >= 5'd8 && p <= 5'd15) begin
				case (m)
				`PPMS_PP_SPI_UART: begin
					pp_src = (p < 5'd12) ? `PPMS_SRC_I2S2 + q
					                     : `PPMS_SRC_UART + q - 7'h04;
				end
				`PPMS_PP_GPIO: begin
					pp_src = (p < 5'd11) ? {2'h0, p} + 7'h0a
					                     : {2'h0, p} + 7'h10;
				end
				`PPMS_PP_SPI_I2S3: begin
					pp_src = (p < 5'd12) ? spi_hi(q)
					                     : `PPMS_SRC_I2S3 + q - 7'h04;
				end
				`PPMS_PP_I2S2_UART: begin
					pp_src = (p < 5'd12) ? `PPMS_SRC_I2S2 + q
					                     : `PPMS_SRC_UART + q - 7'h04;
				end
				`PPMS_PP_SPI_UARTH: begin
					pp_src = (p < 5'd12) ? spi_hi(q)
					                     : `PPMS_SRC_UART + q - 7'h04;
				end
				`PPMS_PP_SPI_I2S: begin
					pp_src = (p < 5'd12) ? `PPMS_SRC_I2S2 + q
					                     : `PPMS_SRC_I2S3 + q - 7'h04;
				end
				default: begin
					pp_src = lcd;
				end
				endcase
			end
		end
	endfunction

	// spi signal on upper data pads 8-11: clk, cs0, rx, tx
	function [`PPMS_SRC_W-1:0] spi_hi;
		input [6:0] q;
		begin
			case (q[1:0])
			2'h0:    spi_hi = `PPMS_SRC_SPI + `PPMS_SPI_CLK;
			2'h1:    spi_hi = `PPMS_SRC_SPI + `PPMS_SPI_CS0;
			2'h2:    spi_hi = `PPMS_SRC_SPI + `PPMS_SPI_RX;
			default: spi_hi = `PPMS_SRC_SPI + `PPMS_SPI_TX;
			endcase
		end
	endfunction

	// source of serial-port-1 pad s under route code m
	function [`PPMS_SRC_W-1:0] sp1_src;
		input [1:0] m;
		input [2:0] s;
		begin
			case (m)
			`PPMS_SP1_I2S: begin
				sp1_src = (s < 3'd4) ? `PPMS_SRC_I2S1 + {4'h0, s}
				                     : {4'h0, s} + 7'h06;
			end
			`PPMS_SP1_GPIO: begin
				sp1_src = {4'h0, s} + 7'h06;
			end
			default: begin
				sp1_src = `PPMS_SRC_CARD + {4'h0, s};
			end
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// control registers

	reg  [15:0] select_reg;
	reg  [15:0] pd_c_reg;
	reg  [15:0] pd_a_reg;
	wire [2:0]  pp_mode;
	wire [1:0]  sp1_mode;
	wire [5:0]  addr_bits;

	// software loads; the select register is the only routing control
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			select_reg <= `PPMS_SEL_RESET;
			pd_c_reg   <= `PPMS_PD_RESET;
			pd_a_reg   <= `PPMS_PD_RESET;
		end else begin
			if (select_wr_i)
				select_reg <= wr_data_i;
			if (pd_c_wr_i)
				pd_c_reg <= wr_data_i;
			if (pd_a_wr_i)
				pd_a_reg <= wr_data_i;
		end
	end

	assign pp_mode   = select_reg[`PPMS_PP_MSB:`PPMS_PP_LSB];
	assign sp1_mode  = select_reg[`PPMS_SP1_MSB:`PPMS_SP1_LSB];
	assign addr_bits = select_reg[`PPMS_ADDR_MSB:`PPMS_ADDR_LSB];
	assign external_bus_select_reg_o = select_reg;
	assign pulldown_inhibit_reg_c_o  = pd_c_reg;
	assign pulldown_inhibit_reg_a_o  = pd_a_reg;

	// pulldowns follow inhibit bits only, whatever the routing
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pport_pulldown_en_o  <= 14'h3fff;
			sport1_pulldown_en_o <= 6'h3f;
		end else begin
			pport_pulldown_en_o  <= ~pd_c_reg[`PPMS_PDC_MSB:`PPMS_PDC_LSB];
			sport1_pulldown_en_o <= ~pd_a_reg[`PPMS_PDA_MSB:`PPMS_PDA_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flattened source vectors, index order as the source map

	wire [`PPMS_SRC_N-1:0] src_out;
	wire [`PPMS_SRC_N-1:0] src_oe;
	reg  [`PPMS_SRC_N-1:0] next_src_in;
	reg  [`PPMS_SRC_N-1:0] src_in;
	reg  [`PPMS_SRC_W-1:0] pad_sel [0:`PPMS_PAD_N-1];
	integer                i;
	integer                j;

	assign src_out = {mem_addr_i, i2s1_out_i, card1_out_i, i2s3_out_i,
	                  i2s2_out_i, uart_out_i, spi_out_i, lcd_out_i,
	                  gp_out_i};
	assign src_oe  = {6'h3f, i2s1_oe_i, card1_oe_i, i2s3_oe_i,
	                  i2s2_oe_i, uart_oe_i, spi_oe_i, lcd_oe_i, gp_oe_i};

	// per pad source selection
	always @* begin
		for (i = 0; i < `PPMS_PAD_SP1; i = i + 1)
			pad_sel[i] = pp_src(pp_mode, i[4:0]);
		for (i = 0; i < 6; i = i + 1) begin
			pad_sel[`PPMS_PAD_SP1 + i] = sp1_src(sp1_mode, i[2:0]);
			pad_sel[`PPMS_PAD_ADDR + i] = addr_bits[i] ?
				`PPMS_SRC_GP + 7'h15 + i[6:0] :
				`PPMS_SRC_ADDR + i[6:0];
		end
	end

	// return each pad level to the source that owns it, others read 0
	always @* begin
		next_src_in = {`PPMS_SRC_N{1'b0}};
		for (j = 0; j < `PPMS_PAD_N; j = j + 1)
			next_src_in[pad_sel[j]] = next_src_in[pad_sel[j]] |
			                          pad_in_i[j];
	end

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			src_in <= {`PPMS_SRC_N{1'b0}};
		else
			src_in <= next_src_in;
	end

	assign gp_in_o    = src_in[31:0];
	assign lcd_in_o   = src_in[52:32];
	assign spi_in_o   = src_in[59:53];
	assign uart_in_o  = src_in[63:60];
	assign i2s2_in_o  = src_in[67:64];
	assign i2s3_in_o  = src_in[71:68];
	assign card1_in_o = src_in[77:72];
	assign i2s1_in_o  = src_in[81:78];

	////////////////////////////////////////////////////////////////////////
	// pad drivers

	genvar g;
	generate
		for (g = 0; g < `PPMS_PAD_N; g = g + 1) begin : gen_pad
			ppms_pin_slice u_slice (
				.clock_i   (clock_i),
				.rst_n_i   (rst_n_i),
				.sel_i     (pad_sel[g]),
				.src_out_i (src_out),
				.src_oe_i  (src_oe),
				.pad_out_o (pad_out_o[g]),
				.pad_oe_o  (pad_oe_o[g])
			);
		end
	endgenerate

endmodule // ppms_pin_mux
`default_nettype wire

/* testbench/ppms_pin_mux_assertions.sv */
// ppms_pin_mux_assertions.sv - route and register checks of the pin mux
// assumes binding into ppms_pin_mux, one clock domain
`timescale 1ns/10ps
`default_nettype none

module ppms_chk (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        select_wr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic [15:0] external_bus_select_reg_o,
	input  wire logic [15:0] pulldown_inhibit_reg_c_o,
	input  wire logic [15:2] pport_pulldown_en_o,
	input  wire logic [32:0] pad_out_o,
	input  wire logic [31:0] gp_out_i,
	input  wire logic [6:0]  spi_out_i,
	input  wire logic [20:0] lcd_out_i,
	input  wire logic [5:0]  card1_out_i
);
	// route fields of the select register
	wire [2:0] pp = external_bus_select_reg_o[14:12];
	wire [1:0] sp = external_bus_select_reg_o[11:10];
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
////////////////////////////////////////////////////////////////////////////////
	chk_sel_load: assert property (select_wr_i |=>
		external_bus_select_reg_o == $past(wr_data_i)) else $error("sel load");
	chk_pd_follow: assert property (1'b1 |=>
		pport_pulldown_en_o == ~$past(pulldown_inhibit_reg_c_o[15:2]))
		else $error("pulldown enable");
	chk_lcd_own: assert property ((pp == 3'h0 || pp == 3'h7) |=>
		pad_out_o[20:0] == $past(lcd_out_i)) else $error("lcd route");
	chk_spi_ctl: assert property ((pp == 3'h1 || pp == 3'h6) |=>
		{pad_out_o[20:16], pad_out_o[1:0]} ==
		$past({spi_out_i[4:0], spi_out_i[6:5]})) else $error("spi route");
	chk_gpio_hi: assert property (pp == 3'h2 |=>
		pad_out_o[15:8] == $past({gp_out_i[31:27], gp_out_i[20:18]}))
		else $error("gpio route");
	chk_spi_hi: assert property ((pp == 3'h3 || pp == 3'h5) |=>
		pad_out_o[11:8] == $past({spi_out_i[6:5], spi_out_i[1:0]}))
		else $error("spi high route");
	chk_card_own: assert property ((sp == 2'h0 || sp == 2'h3) |=>
		pad_out_o[26:21] == $past(card1_out_i)) else $error("card route");
	chk_sp1_gpio: assert property (sp == 2'h2 |=>
		pad_out_o[26:21] == $past(gp_out_i[11:6])) else $error("serial gpio");
	// main scenarios
	cov_mode6: cover property (pp == 3'h6);
	cov_i2s1: cover property (sp == 2'h1);
	cov_b2b: cover property (select_wr_i ##1 select_wr_i);
endmodule // ppms_chk

bind ppms_pin_mux ppms_chk i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.select_wr_i(select_wr_i), .wr_data_i(wr_data_i),
	.external_bus_select_reg_o(external_bus_select_reg_o),
	.pulldown_inhibit_reg_c_o(pulldown_inhibit_reg_c_o),
	.pport_pulldown_en_o(pport_pulldown_en_o), .pad_out_o(pad_out_o),
	.gp_out_i(gp_out_i), .spi_out_i(spi_out_i), .lcd_out_i(lcd_out_i),
	.card1_out_i(card1_out_i));
`default_nettype wire

/* testbench/ppms_board.sv */
// ppms_board.sv - board side of the shared pads
// assumes a pad is released whenever the mux enable is low
`timescale 1ns/10ps
`default_nettype none

module ppms_board (
	input  wire logic [32:0] pad_out_i,
	input  wire logic [32:0] pad_oe_i,
	input  wire logic [32:0] ext_i,
	output logic      [32:0] pad_level_o
);
	// driven pads show the mux, released ones the board driver
	assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule // ppms_board
`default_nettype wire

/* testbench/testbench.sv */
// testbench.sv - self-checking bench of the pin multiplexer
// assumes ppms_pin_mux under hw/ and the board model beside this file
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        sel_wr = 1'b0;
	logic        pdc_wr = 1'b0;
	logic        pda_wr = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [31:0] gp = 32'ha80c_db40;
	logic [20:0] lcd = 21'h0ea5c3;
	logic [6:0]  spi = 7'h53;
	logic [3:0]  uart = 4'h9, i2s2 = 4'h6, i2s3 = 4'hc, i2s1 = 4'h5;
	logic [5:0]  card = 6'h12, maddr = 6'h2a;
	logic [32:0] ext = 33'h0_a5a5_5a5a;
	logic [15:0] sel_q;
	logic [15:2] pp_pd;
	logic [5:0]  sp_pd;
	logic [32:0] pad_in, pad_out, pad_oe;
	logic [20:0] lcd_in;
	logic [6:0]  spi_in;
	logic [31:0] gp_in;
	logic [3:0]  uart_in, i2s2_in, i2s3_in, i2s1_in;
	logic [5:0]  card_in;
	logic [15:0] pdc_q, pda_q;
	int          err_total = 0, checked = 0, cycles = 0;
	// select, address out, address oe, serial pads, parallel pads
	logic [54:0] rows [8] = '{
		{16'h0000, 6'h2a, 6'h3f, 6'h12, 21'h0ea5c3},
		{16'h1400, 6'h2a, 6'h3f, 6'h25, 21'h139636},
		{16'h2800, 6'h2a, 6'h3f, 6'h2d, 21'h0eabc3},
		{16'h3c00, 6'h2a, 6'h3f, 6'h12, 21'h0ecbc3},
		{16'h403f, 6'h00, 6'h3f, 6'h12, 21'h0e96c3},
		{16'h5000, 6'h2a, 6'h3f, 6'h12, 21'h0e9bc3},
		{16'h6000, 6'h2a, 6'h3f, 6'h12, 21'h13c636},
		{16'h7000, 6'h2a, 6'h3f, 6'h12, 21'h0ea5c3}};

	ppms_pin_mux i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.select_wr_i(sel_wr), .pd_c_wr_i(pdc_wr), .pd_a_wr_i(pda_wr),
		.wr_data_i(wdata), .external_bus_select_reg_o(sel_q),
		.pulldown_inhibit_reg_c_o(pdc_q), .pulldown_inhibit_reg_a_o(pda_q),
		.pport_pulldown_en_o(pp_pd), .sport1_pulldown_en_o(sp_pd),
		.pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
		// enables are the inverse of the data so a swapped path shows
		.gp_out_i(gp), .gp_oe_i(~gp), .gp_in_o(gp_in),
		.lcd_out_i(lcd), .lcd_oe_i(~lcd), .lcd_in_o(lcd_in),
		.spi_out_i(spi), .spi_oe_i(~spi), .spi_in_o(spi_in),
		.uart_out_i(uart), .uart_oe_i(~uart), .uart_in_o(uart_in),
		.i2s2_out_i(i2s2), .i2s2_oe_i(~i2s2), .i2s2_in_o(i2s2_in),
		.i2s3_out_i(i2s3), .i2s3_oe_i(~i2s3), .i2s3_in_o(i2s3_in),
		.card1_out_i(card), .card1_oe_i(~card), .card1_in_o(card_in),
		.i2s1_out_i(i2s1), .i2s1_oe_i(~i2s1), .i2s1_in_o(i2s1_in),
		.mem_addr_i(maddr));
	ppms_board i_board (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
		.ext_i(ext), .pad_level_o(pad_in));
////////////////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	always #20 clock_i = ~clock_i;

	// cycle ceiling cuts a hang short
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic cmp_pads(input string what, input logic [32:0] exp,
		input logic [32:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_reg(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one write with the strobes in which, settled two edges later
	task automatic wr(input logic [2:0] which, input logic [15:0] v);
		@(posedge clock_i);
		{pda_wr, pdc_wr, sel_wr} <= which;
		wdata <= v;
		@(posedge clock_i);
		{pda_wr, pdc_wr, sel_wr} <= 3'h0;
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	// reset, route table, then the awkward cases
	initial begin
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(negedge clock_i);
		cmp_reg("select", 16'h0000, sel_q);
		cmp_reg("pulldown c", 16'hfffc, {pp_pd, 2'h0});
		cmp_reg("pulldown a", 16'h003f, {10'h0, sp_pd});
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wr(3'h1, rows[i][54:39]);
			cmp_reg("select", rows[i][54:39], sel_q);
			cmp_pads("pad out", {rows[i][38:33], rows[i][26:0]}, pad_out);
			cmp_pads("pad oe", {rows[i][32:27], ~rows[i][26:0]}, pad_oe);
			$display("test mode %0d done", i);
		end
		cmp_pads("lcd in", {12'h0, lcd & ext[20:0]}, {12'h0, lcd_in});
		cmp_pads("card in", {27'h0, card & ext[26:21]}, {27'h0, card_in});
		cmp_pads("spi in", 33'h0, {26'h0, spi_in});
		cmp_pads("gp in", 33'h0, {1'b0, gp_in});
		cmp_pads("others in", 33'h0,
			{17'h0, uart_in, i2s2_in, i2s3_in, i2s1_in});
		$display("test inputs done");
		@(posedge clock_i);
		sel_wr <= 1'b1;
		wdata <= 16'h1000;
		wr(3'h7, 16'h5015);
		cmp_reg("select", 16'h5015, sel_q);
		cmp_reg("pulldown c", ~16'h5015 & 16'hfffc, {pp_pd, 2'h0});
		cmp_reg("pulldown a", 16'h002a, {10'h0, sp_pd});
		cmp_reg("inhibit c", 16'h5015, pdc_q);
		cmp_reg("inhibit a", 16'h5015, pda_q);
		cmp_pads("pad out", {6'h2a, 6'h12, 21'h0e9bc3}, pad_out);
		cmp_pads("pad oe", {6'h3f, ~{6'h12, 21'h0e9bc3}}, pad_oe);
		cmp_pads("spi in", 33'h42, {26'h0, spi_in});
		cmp_pads("uart in", 33'h1, {29'h0, uart_in});
		$display("test back to back done");
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		@(negedge clock_i);
		cmp_reg("select", 16'h0000, sel_q);
		cmp_pads("pad out", 33'h0, pad_out);
		@(posedge clock_i);
		rst_n_i <= 1'b1;
		// first edge after release loads the mode 0 routes
		@(posedge clock_i);
		@(negedge clock_i);
		cmp_reg("select", 16'h0000, sel_q);
		cmp_pads("pad out", {6'h2a, card, lcd}, pad_out);
		cmp_pads("pad oe", {6'h3f, ~card, ~lcd}, pad_oe);
		$display("test mid reset done");
		complete_run();
	end
endmodule // testbench
`default_nettype wire
